// file: src/adcr_regs.svh
// adcr_regs.svh: bit counts and codes of the serial converter readout
// assumes: included by the package and the top module by its bare name
`ifndef ADCR_REGS_SVH
`define ADCR_REGS_SVH

`define ADCR_RES_BITS      12
`define ADCR_CNT_W         5
`define ADCR_FALL_NULL     5'd2
`define ADCR_FALL_MSB      5'd3
`define ADCR_FALL_LSB      5'd14
`define ADCR_FALL_PD_SHORT 5'd14
`define ADCR_FALL_REPEAT   5'd15
`define ADCR_FALL_PD_LONG  5'd16
`define ADCR_FALL_LAST     5'd25
`define ADCR_FALL_SAMPLE   5'd2
`define ADCR_POS_FULL      12'h7ff
`define ADCR_NEG_FULL      12'h800

`endif

// file: src/adcr_pkg.sv
// adcr_pkg.sv: types of the converter readout block
// assumes: adcr_regs.svh is on the include path
`include "adcr_regs.svh"

package adcr_pkg;

    // frame states, gray along idle -> sample -> shift -> repeat
    typedef enum logic [1:0] {
        ADCR_IDLE   = 2'b00,
        ADCR_SAMPLE = 2'b01,
        ADCR_SHIFT  = 2'b11,
        ADCR_REPEAT = 2'b10
    } adcr_state_t;

    // power status seen by the analog side
    typedef struct packed {
        logic analog_on;
        logic digital_on;
        logic out_on;
    } adcr_power_t;

endpackage : adcr_pkg

// file: src/adcr_top.sv
// adcr_top.sv: serial readout and power control of a 12-bit converter
// assumes: select and serial clock come from a host master on another
// clock; comparator decisions arrive one per step from the analog array
//
// Notes on behaviour
// - each result bit is changed on a falling serial clock edge
// - null bit at second fall, then 12 bits msb first from third fall
// - select still low after lsb: repeat lsb-first without lsb, then float
// - results are two's complement, 7ff positive and 800 negative full scale
// - power down on select rise or 14th clock fall, first wins
// - analog off at conversion end; digital off only while select high
// - each bit goes out as soon as its approximation step completes
// - select rising mid-frame aborts the conversion and powers down
// - a new conversion only starts on a fresh select fall
// - in burst, output register powers down and floats after final bit
// - select low past 15th fall keeps output powered through repeat
// - select falling with clock high still takes the next clock fall as the first
// - sample window spans select fall to second clock fall, two serial periods with the bench host
`timescale 1ns/1ps
`default_nettype none
`include "adcr_regs.svh"

module adcr_top (
    // clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rstn_i,
    // serial link from the host
    input  wire logic                       sel_n_i,
    input  wire logic                       sclk_i,
    output logic                            sdata_o,
    output logic                            sdata_oe_o,
    // analog array interface
    input  wire logic                       cmp_i,
    output logic                            sample_o,
    output logic                            step_o,
    output logic [`ADCR_RES_BITS-1:0]       result_o,
    output adcr_pkg::adcr_power_t           power_o
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [1:0] sel_sync_r;
    logic [1:0] sclk_sync_r;
    logic       sel_d_r;
    logic       sclk_d_r;

    // two stages each, the first stage read only by the second
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sel_sync_r  <= 2'h3;
            sclk_sync_r <= 2'h0;
            sel_d_r     <= 1'b1;
            sclk_d_r    <= 1'b0;
        end else begin
            sel_sync_r  <= {sel_sync_r[0], sel_n_i};
            sclk_sync_r <= {sclk_sync_r[0], sclk_i};
            sel_d_r     <= sel_sync_r[1];
            sclk_d_r    <= sclk_sync_r[1];
        end
    end

    logic sel_n;
    logic sel_fall;
    logic sclk_fall;
    assign sel_n     = sel_sync_r[1];
    // counting starts at the synchronised select fall, so after a select fall with the clock high
    // the next clock fall counts as the first; the host keeps the clock low there
    assign sel_fall  = sel_d_r & ~sel_n;
    // clock edges only count while selected
    assign sclk_fall = sclk_d_r & ~sclk_sync_r[1] & ~sel_n;

    // ------------------------------------------------------------
    // frame state
    // ------------------------------------------------------------
    adcr_pkg::adcr_state_t          state_r, state_nxt;
    logic [`ADCR_CNT_W-1:0]         falls_r, falls_nxt;
    logic [`ADCR_RES_BITS-1:0]      res_r, res_nxt;
    logic [`ADCR_CNT_W-1:0]         rep_idx_r, rep_idx_nxt;
    logic                           dout_r, dout_nxt;
    logic                           oe_r, oe_nxt;
    logic                           analog_r, analog_nxt;

    // bit index of the msb-first field for a given fall count
    function automatic logic [3:0] msb_idx(input logic [`ADCR_CNT_W-1:0] f);
        logic [`ADCR_CNT_W-1:0] d;
        d = `ADCR_FALL_LSB - f;
        return d[3:0];
    endfunction

    // next-state logic for one frame
    always_comb begin
        state_nxt   = state_r;
        falls_nxt   = falls_r;
        res_nxt     = res_r;
        rep_idx_nxt = rep_idx_r;
        dout_nxt    = dout_r;
        oe_nxt      = oe_r;
        analog_nxt  = analog_r;
        if (sel_n) begin
            // select high: abort, full power down, float
            state_nxt  = adcr_pkg::ADCR_IDLE;
            oe_nxt     = 1'b0;
            analog_nxt = 1'b0;
            falls_nxt  = '0;
        end else if (sel_fall) begin
            // fresh select fall starts sampling, counter cleared
            state_nxt  = adcr_pkg::ADCR_SAMPLE;
            falls_nxt  = '0;
            analog_nxt = 1'b1;
            oe_nxt     = 1'b0;
            res_nxt    = '0;
        end else if (sclk_fall && state_r != adcr_pkg::ADCR_IDLE) begin
            falls_nxt = falls_r + 5'd1;
            case (state_r)
                adcr_pkg::ADCR_SAMPLE: begin
                    if (falls_nxt == `ADCR_FALL_NULL) begin
                        state_nxt = adcr_pkg::ADCR_SHIFT;
                        oe_nxt    = 1'b1;
                        dout_nxt  = 1'b0;            // null bit
                    end
                end
                adcr_pkg::ADCR_SHIFT: begin
                    if (falls_nxt <= `ADCR_FALL_LSB) begin
                        // decision of this step goes out at once
                        res_nxt[msb_idx(falls_nxt)] = cmp_i;
                        dout_nxt = cmp_i;
                    end
                    if (falls_nxt == `ADCR_FALL_PD_SHORT) begin
                        analog_nxt = 1'b0;
                    end else if (falls_nxt == `ADCR_FALL_REPEAT) begin
                        state_nxt   = adcr_pkg::ADCR_REPEAT;
                        rep_idx_nxt = 5'd1;
                        dout_nxt    = res_r[1];
                    end
                end
                adcr_pkg::ADCR_REPEAT: begin
                    if (falls_nxt > `ADCR_FALL_LAST) begin
                        state_nxt = adcr_pkg::ADCR_IDLE;
                        oe_nxt    = 1'b0;
                    end else begin
                        rep_idx_nxt = rep_idx_r + 5'd1;
                        dout_nxt    = res_r[rep_idx_nxt[3:0]];
                    end
                end
                default: begin
                    state_nxt = adcr_pkg::ADCR_IDLE;
                end
            endcase
        end
    end

    // frame registers
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r   <= adcr_pkg::ADCR_IDLE;
            falls_r   <= '0;
            res_r     <= '0;
            rep_idx_r <= '0;
            dout_r    <= 1'b0;
            oe_r      <= 1'b0;
            analog_r  <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            falls_r   <= falls_nxt;
            res_r     <= res_nxt;
            rep_idx_r <= rep_idx_nxt;
            dout_r    <= dout_nxt;
            oe_r      <= oe_nxt;
            analog_r  <= analog_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // result register holds the completed code between frames
    logic [`ADCR_RES_BITS-1:0] result_r, result_nxt;
    logic                      step_r, step_nxt;

    always_comb begin
        result_nxt = result_r;
        step_nxt   = 1'b0;
        if (sclk_fall && state_r == adcr_pkg::ADCR_SHIFT
            && falls_nxt <= `ADCR_FALL_LSB) begin
            step_nxt = 1'b1;
        end
        if (sclk_fall && state_r == adcr_pkg::ADCR_SHIFT
            && falls_nxt == `ADCR_FALL_LSB) begin
            result_nxt = {res_r[`ADCR_RES_BITS-1:1], cmp_i};
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            result_r <= '0;
            step_r   <= 1'b0;
        end else begin
            result_r <= result_nxt;
            step_r   <= step_nxt;
        end
    end

    assign sdata_o    = dout_r;
    assign sdata_oe_o = oe_r;
    assign step_o     = step_r;
    assign result_o   = result_r;
    // sampling from select fall to second clock fall
    assign sample_o   = (state_r == adcr_pkg::ADCR_SAMPLE);
    // digital stays powered whenever select is low, even after conversion
    assign power_o    = '{analog_on: analog_r, digital_on: ~sel_n,
                          out_on: oe_r};

endmodule : adcr_top
`default_nettype wire

// file: bench/adcr_monitor.sv
// adcr_monitor.sv: timing checks on the converter readout ports
// assumes: bound into adcr_top; select and clock arrive unsynchronised
`timescale 1ns/1ps
`default_nettype none
`include "adcr_regs.svh"
// ----------------------------------------
// checker
// ----------------------------------------
module adcr_monitor (
    input  wire logic                       clk_i,
    input  wire logic                       rstn_i,
    input  wire logic                       sel_n_i,
    input  wire logic                       sclk_i,
    input  wire logic                       sdata_o,
    input  wire logic                       sdata_oe_o,
    input  wire logic                       cmp_i,
    input  wire logic                       sample_o,
    input  wire logic                       step_o,
    input  wire logic [`ADCR_RES_BITS-1:0]  result_o,
    input  wire adcr_pkg::adcr_power_t      power_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // margins cover the two-stage synchroniser plus the edge register
    sequence s_sel_hi; sel_n_i[*5]; endsequence
    sequence s_sel_lo; !sel_n_i[*4]; endsequence
    a_idle_float: assert property (s_sel_hi |-> !sdata_oe_o) else $error("driving while idle");
    a_abort_off: assert property (s_sel_hi |-> !power_o.analog_on && !power_o.out_on) else $error("powered after select high");
    a_digital_off: assert property (s_sel_hi |-> !power_o.digital_on) else $error("digital on while idle");
    a_digital_on: assert property (s_sel_lo |-> power_o.digital_on) else $error("digital off in frame");
    a_step_single: assert property ($rose(step_o) |=> !step_o) else $error("step pulse too long");
    a_null_first: assert property ($rose(sdata_oe_o) |-> !sdata_o && !sample_o) else $error("null bit wrong");
    a_sample_start: assert property ($fell(sel_n_i) |-> ##[2:4] sample_o) else $error("no sample window");
    a_result_hold: assert property (!$stable(result_o) |-> ##[0:1] !power_o.analog_on) else $error("result moved early");
    a_step_driven: assert property (step_o |-> sdata_oe_o && !sample_o) else $error("step without output");
endmodule // adcr_monitor
bind adcr_top adcr_monitor u_mon (.clk_i, .rstn_i, .sel_n_i, .sclk_i, .sdata_o, .sdata_oe_o,
    .cmp_i, .sample_o, .step_o, .result_o, .power_o);
`default_nettype wire

// file: bench/adcr_host.sv
// adcr_host.sv: host serial master, one frame per go pulse
// assumes: the bench supplies the fall count before raising go
`timescale 1ns/1ps
`default_nettype none
module adcr_host (
    input  wire logic       go_i,
    input  wire logic [4:0] nf_i,
    output logic            sel_n_o,
    output logic            sclk_o,
    output logic [4:0]      fc_o
);
    // clock rests low between frames, so select always falls in the low phase;
    // select rises half a period after the last fall, once that bit is taken
    initial begin
        sel_n_o = 1'b1;
        sclk_o = 1'b0;
        fc_o = 5'h00;
        forever begin
            @(posedge go_i);
            fc_o = 5'h00;
            #100 sel_n_o = 1'b0;
            repeat (nf_i) begin
                #400 sclk_o = 1'b1;
                #400 sclk_o = 1'b0;
                fc_o = fc_o + 5'h01;
            end
            #400 sel_n_o = 1'b1;
        end
    end
endmodule // adcr_host
`default_nettype wire

// file: bench/tb_adc_serial_readout_power_control.sv
// tb_adc_serial_readout_power_control.sv: frames of several lengths and codes
// assumes: host model drives the link at 800 ns per serial period
`timescale 1ns/1ps
`default_nettype none
module tb_adc_serial_readout_power_control;
    logic clk_i, rstn_i, cmp_i, go, sel_n, sclk, sdata, oe, smp, stp;
    logic [4:0] nf, fc;
    logic [11:0] code, res, last;
    adcr_pkg::adcr_power_t pw;
    int miscompares = 0;
    int num_checks = 0;
    int nsteps = 0;
    adcr_top u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .sel_n_i(sel_n), .sclk_i(sclk),
        .sdata_o(sdata), .sdata_oe_o(oe), .cmp_i(cmp_i), .sample_o(smp), .step_o(stp),
        .result_o(res), .power_o(pw));
    adcr_host u_host (.go_i(go), .nf_i(nf), .sel_n_o(sel_n), .sclk_o(sclk), .fc_o(fc));
    // ----------------------------------------
    // clock, comparator feed, checks
    // ----------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // comparator answers msb first, one decision per counted fall
    always @(posedge clk_i) cmp_i <= #10 (fc >= 5'd3 && fc <= 5'd14) ? code[5'd14 - fc] : 1'b0;
    // running count of approximation step pulses
    always @(posedge clk_i) if (stp === 1'b1) nsteps <= nsteps + 1;
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // one frame of n falls; bit checked well after each fall settles
    task automatic frame(input logic [11:0] c, input logic [4:0] n);
        logic eo, eb;
        int s0;
        code = c;
        nf = n;
        s0 = nsteps;
        @(posedge clk_i);
        #10 go = 1'b1;
        for (int k = 1; k <= n; k++) begin
            @(negedge sclk);
            repeat (5) @(posedge clk_i);
            #10;
            eo = (k >= 2 && k <= 25);
            eb = (k < 3) ? 1'b0 : (k <= 14) ? c[14 - k] : c[k - 14];
            check({14'h0, oe, oe ? sdata : 1'b0}, {14'h0, eo, eo ? eb : 1'b0});
            check({15'h0, smp}, {15'h0, k == 1});
            check({15'h0, pw.digital_on}, 16'h1);
            if (k == 14) check({pw.analog_on, 3'h0, res}, {1'b0, 3'h0, c});
        end
        go = 1'b0;
        if (n >= 14) last = c;
        repeat (8) @(posedge clk_i);
        #10;
        check({1'b0, pw, res}, {4'h0, last});
        check(16'(nsteps - s0), (n >= 5'd14) ? 16'd12 : (n >= 5'd3) ? 16'(n - 5'd2) : 16'h0);
    endtask
    initial begin
        go = 1'b0;
        nf = 5'h00;
        code = 12'h000;
        last = 12'h000;
        rstn_i = 1'b0;
        repeat (5) @(posedge clk_i);
        #10 rstn_i = 1'b1;
        frame(12'h7ff, 5'd28);
        frame(12'h800, 5'd14);
        frame(12'ha53, 5'd8);
        frame(12'hfff, 5'd20);
        results();
    end
    // watchdog: four frames take about 625 cycles
    initial begin
        #500000;
        miscompares++;
        results();
    end
endmodule // tb_adc_serial_readout_power_control
`default_nettype wire
